/* rtl/aincc_pkg.sv */
// package for the analog command conditioner: setting codes, widths, reset values
// assumes signed two's complement samples, full scale = 2**(W-1)-1
package aincc_pkg;
   localparam int SAMPLE_W = 16;
   localparam int FIFO_DEPTH = 4;
   // second input signal kinds
   localparam logic [2:0] K2_UNUSED = 3'h0;
   localparam logic [2:0] K2_BIP10 = 3'h1;
   localparam logic [2:0] K2_BIP5 = 3'h2;
   localparam logic [2:0] K2_MA420 = 3'h3;
   localparam logic [2:0] K2_MA020 = 3'h4;
   localparam logic [2:0] K2_UNI10 = 3'h5;
   localparam logic [2:0] K2_UNI5 = 3'h6;
   // first input signal kinds
   localparam logic K1_UNUSED = 1'h0;
   localparam logic K1_UNI10 = 1'h1;
   // reset values, upper limits and scale of the settings
   localparam logic [2:0] KIND2_RST = 3'h1;
   localparam logic KIND1_RST = 1'h1;
   localparam logic [11:0] GAIN_RST = 12'h3E8; // 100.0 percent in tenths
   localparam logic [11:0] GAIN_MAX = 12'hBB8; // 300.0 percent
   localparam logic signed [10:0] OFFS_MAX = 11'sh3E8; // 100.0 percent
   localparam logic [9:0] DZONE_MAX = 10'h2EE; // 75.0 percent
   localparam logic [2:0] SMOOTH_MAX = 3'h6;
   localparam logic [9:0] PERMIL = 10'h3E8; // tenth-percent full scale
   // 4-20 mA live zero is a fifth of full scale
   localparam int LIVE_ZERO_DIV = 5;
endpackage

/* rtl/aincc_fifo.sv */
// small synchronous fifo in the ramp path
// assumes one clock, a clock enable and a synchronised active-low reset
`timescale 1ns/1ps
module aincc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////
   // pointers and fill count
   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push)
         wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop)
         rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      if (push && !pop)
         cnt_nxt = cnt_r + 1'b1;
      else if (pop && !push)
         cnt_nxt = cnt_r - 1'b1;
   end

   assign in_ready = ce && (cnt_r != (AW+1)'(DEPTH)); // honest full
   assign out_valid = ce && (cnt_r != '0);
   assign out_data = mem_r[rp_r];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else if (ce)
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage has no reset; only written words are ever read
   always_ff @(posedge clk)
   begin
      if (ce && push)
         mem_r[wp_r] <= in_data;
   end
endmodule

/* rtl/aincc_channel.sv */
// one analog input channel: offset, gain, polarity, deadband, low-pass
// assumes samples already normalised to signed full scale by the caller
`timescale 1ns/1ps
module aincc_channel #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sample_valid,
   input wire logic signed [W-1:0] sample,
   input wire logic polarity_flip,
   input wire logic [11:0] scale,
   input wire logic signed [10:0] zero_shift,
   input wire logic [2:0] smoothing_level,
   input wire logic [9:0] dead_zone,
   input wire logic unipolar,
   output logic signed [W-1:0] value,
   output logic value_valid
);
   localparam logic signed [W+15:0] FS = (W+16)'((1 << (W-1)) - 1);
   logic signed [W+15:0] acc_r, acc_nxt;
   logic signed [W-1:0] val_r, val_nxt;
   logic vld_r, vld_nxt;
   logic signed [W+15:0] shifted, scaled, band, banded, target, step;

   // clamp to the command range
   function automatic logic signed [W+15:0] sat(input logic signed [W+15:0] x,
                                                input logic uni);
      logic signed [W+15:0] lo;
      lo = uni ? '0 : -FS;
      sat = (x > FS) ? FS : ((x < lo) ? lo : x);
   endfunction

   // fraction of full scale given in tenths of a percent
   function automatic logic signed [W+15:0] permil(input logic signed [W+15:0] p);
      // divisor kept signed, or a negative offset turns the whole quotient unsigned
      permil = (p * FS) / $signed((W+16)'(aincc_pkg::PERMIL));
   endfunction

   ////////////////////////////////////////////////////////////////////
   // scaling chain and recursive filter
   always_comb
   begin
      shifted = (W+16)'(sample) - permil((W+16)'(zero_shift)); // see [R5]
      scaled = sat((shifted * $signed({1'b0, scale})) / 1000, unipolar); // see [R4] [R13]
      if (polarity_flip) // see [R3]
         scaled = unipolar ? FS - scaled : -scaled;
      // otherwise low maps low and high maps high, see [R2]
      band = permil((W+16)'($signed({1'b0, dead_zone})));
      if (scaled <= band && scaled >= -band) // see [R8]
         banded = '0;
      else
         banded = (scaled > 0) ? scaled - band : scaled + band;
      target = banded;
      // coefficient halves per level; level 0 bypasses, see [R7] [R13]
      step = (target - acc_r) >>> smoothing_level;
      acc_nxt = acc_r;
      val_nxt = val_r;
      vld_nxt = 1'b0;
      if (sample_valid)
      begin
         acc_nxt = (smoothing_level == 3'h0) ? target : acc_r + step;
         val_nxt = W'(sat(acc_nxt, 1'b0));
         vld_nxt = 1'b1;
      end
   end

   assign value = val_r;
   assign value_valid = vld_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_r <= '0;
         val_r <= '0;
         vld_r <= 1'b0;
      end
      else if (ce)
      begin
         acc_r <= acc_nxt;
         val_r <= val_nxt;
         vld_r <= vld_nxt;
      end
   end
endmodule

/* rtl/aincc_top.sv */
// analog command conditioner top: two input channels, fifo, ramp hold
// assumes samples synchronous to ref_clk, settings held static by the operator
// What this block does
// [R1] second input kind codes 0..6: unused, +-10V, +-5V, 4-20mA, 0-20mA, 0-10V, 0-5V
// [R2] polarity normal: low input gives low command, high gives maximum
// [R3] polarity flipped: low input gives maximum command, high gives low
// [R4] scaled value is gain times sample minus offset, gain 0..300 percent
// [R5] offset -100..+100 percent of full scale, default zero, before gain
// [R6] offset trim calibration overwrites the stored offset
// [R7] smoothing level 0 bypass up to 6 strongest, default 0
// [R8] second input dead zone 0..75 percent symmetric about zero
// [R9] option 0 holds ramp output while regenerative limiting is active
// [R10] option 1 ramp output always tracks its input
// [R11] separate polarity, gain, offset, smoothing per input, polarity default clear
// [R12] first input kind: 0 unused, 1 unipolar 0-10V, default 1
// [R13] first-order low-pass per level, results saturated to command range
`timescale 1ns/1ps
module aincc_top #(
   parameter int W = aincc_pkg::SAMPLE_W,
   parameter int DEPTH = aincc_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // converted samples, signed full scale for each input
   input wire logic first_sample_valid,
   input wire logic signed [W-1:0] first_sample,
   input wire logic second_sample_valid,
   input wire logic signed [W-1:0] second_sample,
   // operator settings
   input wire logic first_input_signal_kind,
   input wire logic [2:0] second_input_signal_kind,
   input wire logic first_input_polarity_flip,
   input wire logic second_input_polarity_flip,
   input wire logic [11:0] first_input_scale,
   input wire logic [11:0] second_input_scale,
   input wire logic signed [10:0] first_input_zero_shift,
   input wire logic signed [10:0] second_input_zero_shift,
   input wire logic [2:0] first_input_smoothing_level,
   input wire logic [2:0] second_input_smoothing_level,
   input wire logic [9:0] second_input_dead_zone,
   input wire logic ramp_hold_on_regen_limit,
   // offset trim calibration writes
   input wire logic trim_write,
   input wire logic trim_select,
   input wire logic signed [10:0] trim_value,
   // conditioned commands
   output logic signed [W-1:0] first_command,
   output logic first_command_valid,
   output logic signed [W-1:0] second_command,
   output logic second_command_valid,
   // ramp path toward the speed loop, through the fifo
   input wire logic ramp_in_valid,
   output logic ramp_in_ready,
   input wire logic signed [W-1:0] ramp_in,
   input wire logic regen_limit_active,
   output logic signed [W-1:0] ramp_out,
   output logic ramp_out_valid,
   input wire logic ramp_out_ready,
   output logic [W-1:0] first_trim_offset_unused_dummy
);
   localparam logic signed [W-1:0] FSW = W'((1 << (W-1)) - 1);
   logic rst_s1_r, rst_n_s;
   logic signed [10:0] off1_r, off1_nxt, off2_r, off2_nxt;
   logic signed [10:0] prev1_r, prev2_r; // last seen offset setting ports
   logic [2:0] kind2_r, kind2_nxt;
   logic kind1_r, kind1_nxt;
   logic signed [W-1:0] s2_norm;
   logic uni2, use1, use2;
   logic signed [W-1:0] c1, c2;
   logic v1, v2;
   logic fifo_valid;
   logic [W-1:0] fifo_data;
   logic signed [W-1:0] hold_r, hold_nxt;
   logic ov_r, ov_nxt;
   logic hold;

   // clip a setting to its legal range
   function automatic logic [11:0] clip_u(input logic [11:0] x, input logic [11:0] mx);
      clip_u = (x > mx) ? mx : x;
   endfunction

   function automatic logic signed [10:0] clip_s(input logic signed [10:0] x);
      clip_s = (x > aincc_pkg::OFFS_MAX) ? aincc_pkg::OFFS_MAX :
               ((x < -aincc_pkg::OFFS_MAX) ? -aincc_pkg::OFFS_MAX : x);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_s1_r <= 1'b0;
         rst_n_s <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_s <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // stored offsets and kinds; settings ports follow unless trim overwrites; a second kind code above 6 is ignored
   always_comb
   begin
      off1_nxt = clip_s(first_input_zero_shift);
      off2_nxt = clip_s(second_input_zero_shift);
      if (trim_write && !trim_select) // see [R6]
         off1_nxt = clip_s(trim_value);
      if (trim_write && trim_select) // see [R6]
         off2_nxt = clip_s(trim_value);
      // trimmed value persists only until the setting port changes or a trim write to either input
      if (!trim_write)
      begin
         off1_nxt = (first_input_zero_shift == prev1_r) ? off1_r : off1_nxt;
         off2_nxt = (second_input_zero_shift == prev2_r) ? off2_r : off2_nxt;
      end
      kind1_nxt = first_input_signal_kind;
      kind2_nxt = (second_input_signal_kind > aincc_pkg::K2_UNI5) ?
                  kind2_r : second_input_signal_kind;
   end

   always_ff @(posedge ref_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         off1_r <= '0;
         off2_r <= '0;
         prev1_r <= '0;
         prev2_r <= '0;
         kind1_r <= aincc_pkg::KIND1_RST;
         kind2_r <= aincc_pkg::KIND2_RST;
      end
      else if (clk_en)
      begin
         off1_r <= off1_nxt;
         off2_r <= off2_nxt;
         prev1_r <= first_input_zero_shift; // a change here ends a trim, see [R6]
         prev2_r <= second_input_zero_shift;
         kind1_r <= kind1_nxt;
         kind2_r <= kind2_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // second input kind decode to normalised sample
   always_comb
   begin
      use1 = (kind1_r == aincc_pkg::K1_UNI10); // see [R12]
      use2 = (kind2_r != aincc_pkg::K2_UNUSED); // see [R1]
      uni2 = 1'b1;
      s2_norm = second_sample;
      case (kind2_r) // see [R1]
         aincc_pkg::K2_BIP10: uni2 = 1'b0;
         aincc_pkg::K2_BIP5: uni2 = 1'b0;
         aincc_pkg::K2_MA420:
            // remove live zero, stretch 16 mA span to full scale
            s2_norm = W'((((W+2)'(second_sample) - (W+2)'(FSW / W'(aincc_pkg::LIVE_ZERO_DIV)))
                          * 5) / 4);
         default: s2_norm = second_sample;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // independent channels, see [R11]
   aincc_channel #(.W(W)) u_ch1 (
      .clk(ref_clk),
      .rst_n(rst_n_s),
      .ce(clk_en),
      .sample_valid(first_sample_valid && use1),
      .sample(first_sample),
      .polarity_flip(first_input_polarity_flip),
      .scale(clip_u(first_input_scale, aincc_pkg::GAIN_MAX)),
      .zero_shift(off1_r),
      .smoothing_level((first_input_smoothing_level > aincc_pkg::SMOOTH_MAX) ?
                       aincc_pkg::SMOOTH_MAX : first_input_smoothing_level),
      .dead_zone(10'h000),
      .unipolar(1'b1),
      .value(c1),
      .value_valid(v1)
   );

   aincc_channel #(.W(W)) u_ch2 (
      .clk(ref_clk),
      .rst_n(rst_n_s),
      .ce(clk_en),
      .sample_valid(second_sample_valid && use2),
      .sample(s2_norm),
      .polarity_flip(second_input_polarity_flip),
      .scale(clip_u(second_input_scale, aincc_pkg::GAIN_MAX)),
      .zero_shift(off2_r),
      .smoothing_level((second_input_smoothing_level > aincc_pkg::SMOOTH_MAX) ?
                       aincc_pkg::SMOOTH_MAX : second_input_smoothing_level),
      .dead_zone((second_input_dead_zone > aincc_pkg::DZONE_MAX) ?
                 aincc_pkg::DZONE_MAX : second_input_dead_zone),
      .unipolar(uni2),
      .value(c2),
      .value_valid(v2)
   );

   assign first_command = c1;
   assign first_command_valid = v1;
   assign second_command = c2;
   assign second_command_valid = v2;
   assign first_trim_offset_unused_dummy = W'(off1_r);

   ////////////////////////////////////////////////////////////////////
   // ramp path fifo; stalls while the hold freezes the output
   aincc_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_n_s),
      .ce(clk_en),
      .in_valid(ramp_in_valid),
      .in_ready(ramp_in_ready),
      .in_data(ramp_in),
      .out_valid(fifo_valid),
      .out_ready(!hold && (!ov_r || ramp_out_ready)),
      .out_data(fifo_data)
   );

   ////////////////////////////////////////////////////////////////////
   // ramp output register with regen hold
   always_comb
   begin
      hold = !ramp_hold_on_regen_limit && regen_limit_active; // see [R9] [R10]
      hold_nxt = hold_r;
      ov_nxt = ov_r;
      if (ov_r && ramp_out_ready)
         ov_nxt = 1'b0;
      if (!hold && fifo_valid && (!ov_r || ramp_out_ready)) // see [R10]
      begin
         hold_nxt = W'(fifo_data);
         ov_nxt = 1'b1;
      end
   end

   assign ramp_out = hold_r; // frozen value while held, see [R9]
   assign ramp_out_valid = ov_r;

   always_ff @(posedge ref_clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         hold_r <= '0;
         ov_r <= 1'b0;
      end
      else if (clk_en)
      begin
         hold_r <= hold_nxt;
         ov_r <= ov_nxt;
      end
   end
endmodule

/* sim/aincc_sva.sv */
// checker for the conditioner top: answer pulses, command ranges, ramp hold
// assumes it is bound onto aincc_top, one clock, reset_n active low
`timescale 1ns/1ps
module aincc_sva #(
   parameter int W = 16
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic first_sample_valid,
   input wire logic second_sample_valid,
   input wire logic first_input_signal_kind,
   input wire logic [2:0] second_input_signal_kind,
   input wire logic ramp_hold_on_regen_limit,
   input wire logic regen_limit_active,
   input logic signed [W-1:0] first_command,
   input logic first_command_valid,
   input logic signed [W-1:0] second_command,
   input logic second_command_valid,
   input logic signed [W-1:0] ramp_out,
   input logic ramp_out_valid,
   input wire logic ramp_out_ready,
   input logic ramp_in_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   // kinds held steady so a registered kind cannot lag the sample
   a_first_answers: assert property (
      first_sample_valid && clk_en && first_input_signal_kind
      && $stable(first_input_signal_kind) |=> first_command_valid)
      else $error("first command answer missing");
   a_first_quiet: assert property (
      !(first_sample_valid && clk_en && first_input_signal_kind) |=> !first_command_valid)
      else $error("first command answer without sample");
   a_second_answers: assert property (
      second_sample_valid && clk_en && second_input_signal_kind inside {[1:6]}
      && $stable(second_input_signal_kind) |=> second_command_valid)
      else $error("second command answer missing");
   a_second_refused: assert property (
      second_input_signal_kind == aincc_pkg::K2_UNUSED && $stable(second_input_signal_kind)
      |=> !second_command_valid)
      else $error("unused second input answered");
   a_first_unipolar: assert property (
      first_command_valid |-> !first_command[W-1])
      else $error("first command below zero");
   a_second_unipolar: assert property (
      second_command_valid && $past(second_input_signal_kind) inside {[3:6]}
      |-> !second_command[W-1])
      else $error("unipolar second command below zero");
   a_command_holds: assert property (
      !first_command_valid |-> $stable(first_command))
      else $error("first command moved without a sample");
   a_ramp_freeze: assert property (
      !ramp_hold_on_regen_limit && regen_limit_active |=> $stable(ramp_out))
      else $error("ramp output moved while held");
   a_ramp_stands: assert property (
      ramp_out_valid && !ramp_out_ready |=> ramp_out_valid && $stable(ramp_out))
      else $error("ramp output dropped before taken");
   // main scenarios reached
   c_hold_full: cover property (regen_limit_active && !ramp_in_ready);
   c_second: cover property (second_command_valid);
   c_drain: cover property (ramp_out_valid && ramp_out_ready);
endmodule

/* sim/aincc_loop_model.sv */
// speed loop side of the ramp path: takes words, may stall
// assumes one clock shared with the conditioner
`timescale 1ns/1ps
module aincc_loop_model (
   input wire logic ref_clk,
   input wire logic stall,
   input wire logic ramp_out_valid,
   input wire logic signed [15:0] ramp_out,
   output logic ramp_out_ready
);
   logic signed [15:0] got[$];
   initial ramp_out_ready = 1'b0;
   // ready only moves after an edge, so a word is never taken twice
   always @(posedge ref_clk)
   begin
      if (ramp_out_valid && ramp_out_ready)
         got.push_back(ramp_out);
      ramp_out_ready <= !stall;
   end
endmodule

/* sim/testbench.sv */
// self-checking bench for the conditioner top, one task per scenario
// assumes aincc_sva and aincc_loop_model compiled alongside
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, stall = 1'b0;
   logic first_sample_valid = 1'b0, second_sample_valid = 1'b0, ramp_in_valid = 1'b0;
   logic signed [15:0] first_sample = 16'sh0, second_sample = 16'sh0, ramp_in = 16'sh0;
   logic first_input_signal_kind = 1'b1, first_input_polarity_flip = 1'b0;
   logic second_input_polarity_flip = 1'b0, ramp_hold_on_regen_limit = 1'b0;
   logic regen_limit_active = 1'b0, trim_write = 1'b0, trim_select = 1'b0;
   logic [2:0] second_input_signal_kind = 3'h1, first_input_smoothing_level = 3'h0;
   logic [2:0] second_input_smoothing_level = 3'h0;
   logic [11:0] first_input_scale = 12'h3E8, second_input_scale = 12'h3E8;
   logic signed [10:0] first_input_zero_shift = 11'sh0, second_input_zero_shift = 11'sh0;
   logic signed [10:0] trim_value = 11'sh0;
   logic [9:0] second_input_dead_zone = 10'h0;
   logic signed [15:0] first_command, second_command, ramp_out, held;
   logic first_command_valid, second_command_valid, ramp_in_ready, ramp_out_valid;
   logic ramp_out_ready;
   logic [15:0] first_trim_offset_unused_dummy;
   int num_errors = 0, total_checks = 0, n;
   aincc_top #(.W(16), .DEPTH(4)) aincc_top_inst (.*);
   aincc_loop_model aincc_loop_model_inst (.*);
   always #12.5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic signed [15:0] exp,
      input logic signed [15:0] got, input int tol);
      total_checks++;
      if ((^got === 1'bx) || (got > exp + tol) || (got < exp - tol))
      begin
         num_errors++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // one sample pulse; acc low means no answer may come; returns on a rising edge
   task automatic samp(input bit ch, input bit acc, input logic signed [15:0] s,
      input logic signed [15:0] exp, input int tol);
      @(posedge ref_clk);
      first_sample_valid <= !ch;
      second_sample_valid <= ch;
      first_sample <= s;
      second_sample <= s;
      @(posedge ref_clk);
      first_sample_valid <= 1'b0;
      second_sample_valid <= 1'b0;
      @(negedge ref_clk);
      chk("answer", {15'h0, acc}, {15'h0, ch ? second_command_valid : first_command_valid}, 0);
      if (acc)
         chk(ch ? "second" : "first", exp, ch ? second_command : first_command, tol);
      @(posedge ref_clk);
   endtask
   task automatic t_first();
      samp(0, 1, 16'sh4000, 16'sh4000, 0);
      samp(0, 1, -16'sh0064, 16'sh0, 0);
      first_input_polarity_flip <= 1'b1;
      samp(0, 1, 16'sh4000, 16'sh3FFF, 0);
      first_input_polarity_flip <= 1'b0;
      first_input_scale <= 12'hBB8;
      samp(0, 1, 16'sh4000, 16'sh7FFF, 0);
      first_input_scale <= 12'h1F4;
      samp(0, 1, 16'sh4E20, 16'sh2710, 0);
      first_input_scale <= 12'h3E8;
      first_input_zero_shift <= 11'sh3E8;
      samp(0, 1, 16'sh7FFF, 16'sh0, 0);
      first_input_zero_shift <= -11'sh3E8;
      samp(0, 1, 16'sh0, 16'sh7FFF, 0);
      first_input_zero_shift <= 11'sh0;
   endtask
   // trim overwrites one stored offset and must outlive the write pulse
   task automatic t_trim(input bit sel, input logic signed [10:0] v,
      input logic signed [15:0] exp);
      @(posedge ref_clk);
      trim_select <= sel;
      trim_value <= v;
      trim_write <= 1'b1;
      @(posedge ref_clk);
      trim_write <= 1'b0;
      samp(sel, 1, 16'sh7FFF, exp, 0);
      chk("stored offset", sel ? 16'sh0 : 16'(v), first_trim_offset_unused_dummy, 0);
   endtask
   task automatic t_filter();
      samp(0, 1, 16'sh0, 16'sh0, 0);
      first_input_smoothing_level <= 3'h1;
      samp(0, 1, 16'sh4E20, 16'sh2710, 0);
      samp(0, 1, 16'sh4E20, 16'sh3A98, 0);
      first_input_smoothing_level <= 3'h6;
      samp(0, 1, 16'sh5398, 16'sh3AFC, 0);
      first_input_smoothing_level <= 3'h0;
   endtask
   task automatic t_second();
      // kind 3 has a live zero of a fifth of full scale
      for (int k = 0; k < 7; k++)
      begin
         second_input_signal_kind <= 3'(k);
         samp(1, k != 0, 16'sh38D9, (k == 3) ? 16'sh2710 : 16'sh38D9, 0);
         samp(1, k != 0, -16'sh1388, (k > 2) ? 16'sh0 : -16'sh1388, 0);
      end
      second_input_signal_kind <= 3'h1;
      held = first_command;
      second_input_polarity_flip <= 1'b1;
      samp(1, 1, -16'sh2EE0, 16'sh2EE0, 0);
      chk("first kept", held, first_command, 0);
      second_input_polarity_flip <= 1'b0;
      second_input_dead_zone <= 10'h064;
      samp(1, 1, 16'shBB8, 16'sh0, 0);
      samp(1, 1, -16'shBB8, 16'sh0, 0);
      samp(1, 1, 16'sh2710, 16'sh1A43, 1);
      samp(1, 1, -16'sh2710, -16'sh1A43, 1);
      second_input_dead_zone <= 10'h2EE;
      samp(1, 1, 16'sh5FFF, 16'sh0, 0);
      second_input_dead_zone <= 10'h0;
      first_input_signal_kind <= 1'b0;
      samp(0, 0, 16'sh4000, 16'sh0, 0);
      first_input_signal_kind <= 1'b1;
   endtask
   // clock enable low freezes all state and refuses ramp words
   task automatic t_freeze();
      clk_en <= 1'b0;
      held = first_command;
      samp(0, 0, 16'sh1234, 16'sh0, 0);
      chk("frozen command", held, first_command, 0);
      chk("frozen ready", 16'sh0, {15'h0, ramp_in_ready}, 0);
      clk_en <= 1'b1;
   endtask
   // held ramp fills the fifo while the loop stalls, the released loop then drains it in order
   task automatic t_ramp();
      @(posedge ref_clk);
      regen_limit_active <= 1'b1;
      stall <= 1'b1;
      ramp_in_valid <= 1'b1;
      ramp_in <= 16'sh0100;
      n = 0;
      repeat (10)
      begin
         @(posedge ref_clk);
         if (ramp_in_ready === 1'b1)
         begin
            n++;
            ramp_in <= 16'sh0100 + 16'(n);
         end
      end
      ramp_in_valid <= 1'b0;
      chk("accepted", 16'sh4, 16'(n), 0);
      chk("frozen", 16'sh0, ramp_out, 0);
      regen_limit_active <= 1'b0;
      repeat (5) @(posedge ref_clk);
      stall <= 1'b0;
      for (int i = 0; i < 30 && aincc_loop_model_inst.got.size() < 4; i++)
         @(posedge ref_clk);
      for (int i = 0; i < 4; i++)
         chk("drained", 16'sh0100 + 16'(i), aincc_loop_model_inst.got[i], 0);
      ramp_hold_on_regen_limit <= 1'b1;
      regen_limit_active <= 1'b1;
      ramp_in_valid <= 1'b1;
      ramp_in <= 16'sh0200;
      do @(posedge ref_clk); while (ramp_in_ready !== 1'b1);
      ramp_in_valid <= 1'b0;
      for (int i = 0; i < 10 && aincc_loop_model_inst.got.size() < 5; i++)
         @(posedge ref_clk);
      chk("tracked", 16'sh0200, aincc_loop_model_inst.got[$], 0);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence after a three cycle reset
   initial
   begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_first();
      t_trim(0, 11'sh3E8, 16'sh0);
      t_trim(0, 11'sh0, 16'sh7FFF);
      t_trim(1, 11'sh3E8, 16'sh0);
      t_trim(1, 11'sh0, 16'sh7FFF);
      t_filter();
      t_second();
      t_ramp();
      t_freeze();
      wrap_up();
   end
   // watchdog, far beyond the under two hundred cycles the tests need
   initial
   begin
      #(25 * 20000);
      num_errors++;
      wrap_up();
   end
endmodule
bind aincc_top aincc_sva #(.W(W)) aincc_sva_inst (.*);
